// ===== hdl/scs_clk_gen.sv
`include "scs_consts.svh"

module scs_clk_gen
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // configuration
  scs_gen_if.gen           cfg,
  // trigger pin, asynchronous
  input  wire logic        trig_in,
  // clock phases and results
  output logic             conv_tick,
  output logic             sample_tick,
  output logic             clk_lvl,
  output logic             trig_out,
  output logic [63:0]      timestamp
);

  scs_gen_st_t s_r;
  scs_gen_st_t s_nxt;

  // the counts are in system clock cycles: a model of the real oscillator path
  always_comb begin
    s_nxt = s_r;
    s_nxt.conv_tick   = 1'b0;
    s_nxt.sample_tick = 1'b0;
    s_nxt.trig_s1     = trig_in;
    s_nxt.trig_s2     = s_r.trig_s1;
    if (!cfg.run) begin
      s_nxt.cnt     = 32'h00000000;
      s_nxt.oscnt   = 32'h00000000;
      s_nxt.clk_lvl = 1'b0;
    end else begin
      if (s_r.cnt >= cfg.conv_div - 32'h00000001) begin
        s_nxt.cnt       = 32'h00000000;
        s_nxt.conv_tick = 1'b1;
        s_nxt.ts        = s_r.ts + 64'h0000000000000001;
        s_nxt.pipe      = {s_r.pipe[`SCS_PIPE_DELAY-2:0], s_r.trig_s2};
        if (s_r.oscnt >= cfg.os - 32'h00000001) begin
          s_nxt.oscnt       = 32'h00000000;
          s_nxt.sample_tick = 1'b1;
        end else begin
          s_nxt.oscnt = s_r.oscnt + 32'h00000001;
        end
      end else begin
        s_nxt.cnt = s_r.cnt + 32'h00000001;
      end
      // pin follows the converter clock, not the slower sample rate
      s_nxt.clk_lvl = (s_nxt.cnt < {1'b0, cfg.conv_div[31:1]});
    end
    // the pipeline delay only lines up when converter and sample clocks agree
    s_nxt.trig_out = (cfg.os == 32'h00000001) ? s_r.pipe[`SCS_PIPE_DELAY-1] : s_r.trig_s2;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign conv_tick   = s_r.conv_tick;
  assign sample_tick = s_r.sample_tick;
  assign clk_lvl     = s_r.clk_lvl;
  assign trig_out    = s_r.trig_out;
  assign timestamp   = s_r.ts;

endmodule

// ===== hdl/scs_consts.svh
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// parameter register numbers
`define SCS_ADDR_W            18
`define SCS_ADDR_SRATE        18'h04e20
`define SCS_ADDR_CLKOUT       18'h04e8e
`define SCS_ADDR_CLKOUT_FREQ  18'h04e8f
`define SCS_ADDR_TERM         18'h04e98
`define SCS_ADDR_REF_HZ       18'h04eac
`define SCS_ADDR_MODE         18'h04ee8
`define SCS_ADDR_OS_RATIO     18'h30dbb

////////////////////////////////////////////////////////////////////////////////
// clock source codes, one-hot
`define SCS_MODE_INT_PLL      32'h00000001
`define SCS_MODE_OSC1         32'h00000002
`define SCS_MODE_OSC2         32'h00000004
`define SCS_MODE_EXT_DIRECT   32'h00000008
`define SCS_MODE_EXT_DIV      32'h00000010
`define SCS_MODE_PLL_EXT_REF  32'h00000020
`define SCS_MODE_LEGAL_MASK   32'h0000003f

////////////////////////////////////////////////////////////////////////////////
// frequency limits and board figures, in Hz except the SCS_OSC2_FITTED flag
`define SCS_REF_MIN_HZ        32'h000f4240
`define SCS_REF_MAX_HZ        32'h07735940
`define SCS_RATE_MIN_HZ       32'h000003e8
`define SCS_RATE_MAX_HZ       32'h02faf080
`define SCS_ADC_MIN_HZ        32'h0007a120
`define SCS_OSC2_HZ           32'h02faf080
`define SCS_OSC2_FITTED       1'b1
`define SCS_VCO_MAX_HZ        32'h3b9aca00

////////////////////////////////////////////////////////////////////////////////
// reset values and sizes
`define SCS_RST_MODE          32'h00000001
`define SCS_RST_REF_HZ        32'h00989680
`define SCS_RST_SRATE         32'h02faf080
`define SCS_PIPE_DELAY        8
`define SCS_DIV_STEPS         6'h20

`endif

// ===== hdl/scs_div.sv
`include "scs_consts.svh"

module scs_div
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // request
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [31:0] divisor,
  // answer
  output logic             done,
  output logic [31:0]      quotient
);

  scs_div_st_t s_r;
  scs_div_st_t s_nxt;
  logic [32:0] rem_sh;

  // restoring divider, one quotient bit per cycle; a zero divisor yields all ones
  always_comb begin
    s_nxt  = s_r;
    rem_sh = {s_r.rem, s_r.quo[31]};
    s_nxt.done = 1'b0;
    if (start) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt  = `SCS_DIV_STEPS;
      s_nxt.rem  = 32'h00000000;
      s_nxt.quo  = dividend;
      s_nxt.den  = divisor;
    end else if (s_r.busy) begin
      if (rem_sh >= {1'b0, s_r.den}) begin
        s_nxt.rem = 32'(rem_sh - {1'b0, s_r.den});
        s_nxt.quo = {s_r.quo[30:0], 1'b1};
      end else begin
        s_nxt.rem = rem_sh[31:0];
        s_nxt.quo = {s_r.quo[30:0], 1'b0};
      end
      s_nxt.cnt = s_r.cnt - 6'h01;
      if (s_r.cnt == 6'h01) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done     = s_r.done;
  assign quotient = s_r.quo;

endmodule

// ===== hdl/scs_gen_if.sv
interface scs_gen_if;
  logic [31:0] conv_div;
  logic [31:0] os;
  logic        run;

  modport ctrl (output conv_div, output os, output run);
  modport gen  (input conv_div, input os, input run);
endinterface

// ===== hdl/scs_pkg.sv
`include "scs_consts.svh"

package scs_pkg;

  typedef enum logic [2:0] {
    CS_IDLE  = 3'b000,
    CS_MULT  = 3'b001,
    CS_OS    = 3'b010,
    CS_DIV   = 3'b011,
    CS_FOUT  = 3'b100,
    CS_SRATE = 3'b101
  } scs_calc_t;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  cnt;
    logic [31:0] rem;
    logic [31:0] quo;
    logic [31:0] den;
  } scs_div_st_t;

  typedef struct packed {
    logic [31:0]                cnt;
    logic [31:0]                oscnt;
    logic                       conv_tick;
    logic                       sample_tick;
    logic                       clk_lvl;
    logic                       trig_s1;
    logic                       trig_s2;
    logic                       trig_out;
    logic [`SCS_PIPE_DELAY-1:0] pipe;
    logic [63:0]                ts;
  } scs_gen_st_t;

  typedef struct packed {
    logic [31:0] mode;
    logic        clkout;
    logic        term;
    logic [31:0] ref_hz;
    logic [31:0] desired;
    logic [31:0] achieved;
    logic [31:0] fout;
    logic [31:0] os;
    logic [31:0] conv_div;
    logic [31:0] src;
    logic        pend;
    scs_calc_t   calc;
    logic        div_start;
    logic [31:0] div_a;
    logic [31:0] div_b;
    logic        run;
    logic [31:0] rdata;
    logic        ack;
    logic        err;
    logic        clk_oe;
    logic        term_en;
    logic        ref_ext;
    logic        osc2_sel;
    logic        busy;
  } scs_top_st_t;

endpackage

// ===== hdl/scs_top.sv
// What this block does
// - code 4 selects second on-board oscillator
// - oscillator divider; rate readback gives best match
// - clock out drives connector, internal modes only
// - read back frequency present at clock output
// - code 32 feeds PLL from connector reference
// - reference 1 to 125 MHz sets PLL
// - unreachable rate settles on closest reachable one
// - termination only while connector is input
// - slow rates: converter fast, digital part slow
// - oversampling ratio readable, one when inactive
// - output clock is the real converter clock
// - pipeline compensation only without oversampling
// - timestamp counts at converter clock rate
`include "scs_consts.svh"

module scs_top
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  // parameter register port
  input  wire logic [`SCS_ADDR_W-1:0] par_addr,
  input  wire logic                   par_wr,
  input  wire logic                   par_rd,
  input  wire logic [31:0]            par_wdata,
  output logic [31:0]                 par_rdata,
  output logic                        par_ack,
  output logic                        par_err,
  // clock connector and source steering
  output logic                        ext_clk_o,
  output logic                        ext_clk_oe,
  output logic                        term_en,
  output logic                        pll_ref_ext,
  output logic                        osc2_sel,
  // trigger pin
  input  wire logic                   trig_in,
  // sampling results
  output logic                        trig_out,
  output logic                        conv_tick,
  output logic                        sample_tick,
  output logic [63:0]                 timestamp,
  output logic                        cfg_busy
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] at_least_one(input logic [31:0] v);
    at_least_one = (v == 32'h00000000) ? 32'h00000001 : v;
  endfunction

  // the connector may only carry our clock when no mode uses it as an input
  function automatic logic is_internal(input logic [31:0] m);
    is_internal = (m == `SCS_MODE_INT_PLL) || (m == `SCS_MODE_OSC1) || (m == `SCS_MODE_OSC2);
  endfunction

  function automatic logic is_one_hot(input logic [31:0] v);
    is_one_hot = (v != 32'h00000000) && ((v & (v - 32'h00000001)) == 32'h00000000)
                 && ((v & ~`SCS_MODE_LEGAL_MASK) == 32'h00000000);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state

  scs_top_st_t s_r;
  scs_top_st_t s_nxt;
  logic        div_done;
  logic [31:0] div_q;
  logic [63:0] prod;
  logic [31:0] tgt;
  logic        mode_ok;

  scs_gen_if gen_cfg ();

  ////////////////////////////////////////////////////////////////////////////////
  // register access and rate calculation

  always_comb begin
    s_nxt     = s_r;
    prod      = 64'h0000000000000000;
    tgt       = 32'h00000000;
    mode_ok   = 1'b0;
    s_nxt.ack       = 1'b0;
    s_nxt.err       = 1'b0;
    s_nxt.div_start = 1'b0;

    // ---------------- calculation sequence ----------------
    unique case (s_r.calc)
      CS_IDLE: begin
        if (s_r.pend) begin
          s_nxt.pend = 1'b0;
          if (s_r.mode == `SCS_MODE_OSC2) begin
            s_nxt.src       = `SCS_OSC2_HZ;
            s_nxt.div_a     = `SCS_ADC_MIN_HZ + s_r.desired - 32'h00000001;
            s_nxt.div_b     = s_r.desired;
            s_nxt.div_start = 1'b1;
            s_nxt.calc      = CS_OS;
          end else if (s_r.mode == `SCS_MODE_PLL_EXT_REF) begin
            // largest multiplier that keeps the loop under its top limit
            s_nxt.div_a     = `SCS_VCO_MAX_HZ;
            s_nxt.div_b     = s_r.ref_hz;
            s_nxt.div_start = 1'b1;
            s_nxt.calc      = CS_MULT;
          end else begin
            // other sources are handled elsewhere; our generator rests
            s_nxt.run = 1'b0;
            s_nxt.os  = 32'h00000001;
          end
        end
      end
      CS_MULT: begin
        if (div_done) begin
          prod            = s_r.ref_hz * at_least_one(div_q);
          s_nxt.src       = prod[31:0];
          s_nxt.div_a     = `SCS_ADC_MIN_HZ + s_r.desired - 32'h00000001;
          s_nxt.div_b     = s_r.desired;
          s_nxt.div_start = 1'b1;
          s_nxt.calc      = CS_OS;
        end
      end
      CS_OS: begin
        if (div_done) begin
          // ceiling of converter minimum over the requested rate
          s_nxt.os        = at_least_one(div_q);
          prod            = s_r.desired * at_least_one(div_q);
          tgt             = prod[31:0];
          s_nxt.div_a     = s_r.src + {1'b0, tgt[31:1]};
          s_nxt.div_b     = tgt;
          s_nxt.div_start = 1'b1;
          s_nxt.calc      = CS_DIV;
        end
      end
      CS_DIV: begin
        if (div_done) begin
          // rounded divider gives the closest reachable converter clock
          s_nxt.conv_div  = at_least_one(div_q);
          s_nxt.div_a     = s_r.src;
          s_nxt.div_b     = at_least_one(div_q);
          s_nxt.div_start = 1'b1;
          s_nxt.calc      = CS_FOUT;
        end
      end
      CS_FOUT: begin
        if (div_done) begin
          s_nxt.fout      = div_q;
          s_nxt.div_a     = div_q + {1'b0, s_r.os[31:1]};
          s_nxt.div_b     = s_r.os;
          s_nxt.div_start = 1'b1;
          s_nxt.calc      = CS_SRATE;
        end
      end
      CS_SRATE: begin
        if (div_done) begin
          s_nxt.achieved = div_q;
          s_nxt.run      = 1'b1;
          s_nxt.calc     = CS_IDLE;
        end
      end
      default: begin
        s_nxt.calc = CS_IDLE;
      end
    endcase

    // ---------------- register writes ----------------
    if (par_wr) begin
      s_nxt.ack = 1'b1;
      unique case (par_addr)
        `SCS_ADDR_MODE: begin
          mode_ok = is_one_hot(par_wdata)
                    && ((par_wdata != `SCS_MODE_OSC2) || `SCS_OSC2_FITTED);
          if (mode_ok) begin
            s_nxt.mode = par_wdata;
            s_nxt.pend = 1'b1;
            if (!is_internal(par_wdata)) begin
              s_nxt.clkout = 1'b0;
            end
          end else begin
            s_nxt.err = 1'b1;
          end
        end
        `SCS_ADDR_CLKOUT: begin
          if (par_wdata[0] && !is_internal(s_r.mode)) begin
            s_nxt.err = 1'b1;
          end else begin
            s_nxt.clkout = par_wdata[0];
          end
        end
        `SCS_ADDR_TERM: begin
          s_nxt.term = par_wdata[0];
        end
        `SCS_ADDR_REF_HZ: begin
          if ((par_wdata >= `SCS_REF_MIN_HZ) && (par_wdata <= `SCS_REF_MAX_HZ)) begin
            // no recalculation here: software follows with the sampling rate
            s_nxt.ref_hz = par_wdata;
          end else begin
            s_nxt.err = 1'b1;
          end
        end
        `SCS_ADDR_SRATE: begin
          // out-of-range requests are pulled to the nearest legal rate
          if (par_wdata < `SCS_RATE_MIN_HZ) begin
            s_nxt.desired = `SCS_RATE_MIN_HZ;
          end else if (par_wdata > `SCS_RATE_MAX_HZ) begin
            s_nxt.desired = `SCS_RATE_MAX_HZ;
          end else begin
            s_nxt.desired = par_wdata;
          end
          s_nxt.pend = 1'b1;
        end
        default: begin
          // read-only and unmapped numbers
          s_nxt.err = 1'b1;
        end
      endcase
    end

    // ---------------- register reads ----------------
    if (par_rd && !par_wr) begin
      s_nxt.ack   = 1'b1;
      s_nxt.rdata = 32'h00000000;
      unique case (par_addr)
        `SCS_ADDR_MODE: begin
          s_nxt.rdata = s_r.mode;
        end
        `SCS_ADDR_CLKOUT: begin
          s_nxt.rdata = {31'h00000000, s_r.clkout};
        end
        `SCS_ADDR_CLKOUT_FREQ: begin
          s_nxt.rdata = s_r.clk_oe ? s_r.fout : 32'h00000000;
        end
        `SCS_ADDR_TERM: begin
          s_nxt.rdata = {31'h00000000, s_r.term};
        end
        `SCS_ADDR_REF_HZ: begin
          s_nxt.rdata = s_r.ref_hz;
        end
        `SCS_ADDR_SRATE: begin
          s_nxt.rdata = s_r.achieved;
        end
        `SCS_ADDR_OS_RATIO: begin
          s_nxt.rdata = s_r.run ? s_r.os : 32'h00000001;
        end
        default: begin
          s_nxt.err = 1'b1;
        end
      endcase
    end

    // ---------------- pin steering ----------------
    s_nxt.osc2_sel = (s_nxt.mode == `SCS_MODE_OSC2);
    s_nxt.ref_ext  = (s_nxt.mode == `SCS_MODE_PLL_EXT_REF);
    s_nxt.clk_oe   = s_nxt.clkout && is_internal(s_nxt.mode);
    // a driven connector is an output, so the load must stay off
    s_nxt.term_en  = s_nxt.term && !s_nxt.clk_oe;
    // registered so the busy pin comes straight from a flop
    s_nxt.busy     = s_nxt.pend || (s_nxt.calc != CS_IDLE);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_r          <= '0;
      s_r.mode     <= `SCS_RST_MODE;
      s_r.ref_hz   <= `SCS_RST_REF_HZ;
      s_r.desired  <= `SCS_RST_SRATE;
      s_r.achieved <= `SCS_RST_SRATE;
      s_r.os       <= 32'h00000001;
      s_r.conv_div <= 32'h00000001;
      s_r.calc     <= CS_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared divider and clock phase generator

  scs_div u_div (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .start    (s_r.div_start),
    .dividend (s_r.div_a),
    .divisor  (s_r.div_b),
    .done     (div_done),
    .quotient (div_q)
  );

  // os and conv_div reach the generator as soon as CS_OS and CS_DIV write them; run is set only at the end
  assign gen_cfg.conv_div = s_r.conv_div;
  assign gen_cfg.os       = s_r.os;
  assign gen_cfg.run      = s_r.run;

  scs_clk_gen u_gen (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .cfg         (gen_cfg),
    .trig_in     (trig_in),
    .conv_tick   (conv_tick),
    .sample_tick (sample_tick),
    .clk_lvl     (ext_clk_o),
    .trig_out    (trig_out),
    .timestamp   (timestamp)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign par_rdata   = s_r.rdata;
  assign par_ack     = s_r.ack;
  assign par_err     = s_r.err;
  assign ext_clk_oe  = s_r.clk_oe;
  assign term_en     = s_r.term_en;
  assign pll_ref_ext = s_r.ref_ext;
  assign osc2_sel    = s_r.osc2_sel;
  assign cfg_busy    = s_r.busy;

endmodule

// ===== testbench/scs_ext_clk_src.sv
module scs_ext_clk_src #(
  // frequency that software has to program as the reference
  parameter int REF_HZ = 10000000
) (
  // connector as the board leaves it
  input  wire logic drv_oe,
  input  wire logic drv_lvl,
  // resolved connector level
  output logic      conn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  // a reference source runs free, it never pauses between acquisitions
  initial forever #(500000000.0 / REF_HZ) ref_clk = ~ref_clk;
  // the source backs off while the board drives the connector
  assign conn = drv_oe ? drv_lvl : ref_clk;
endmodule

// ===== testbench/scs_top_monitor.sv
`include "scs_consts.svh"
module scs_top_monitor
  import scs_pkg::*;
(
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   resetn,
  // register port
  input wire logic [`SCS_ADDR_W-1:0] par_addr,
  input wire logic                   par_wr,
  input wire logic                   par_rd,
  input wire logic [31:0]            par_wdata,
  input wire logic [31:0]            par_rdata,
  input wire logic                   par_ack,
  input wire logic                   par_err,
  // connector and steering
  input wire logic                   ext_clk_o,
  input wire logic                   ext_clk_oe,
  input wire logic                   term_en,
  input wire logic                   pll_ref_ext,
  input wire logic                   osc2_sel,
  // sampling
  input wire logic                   trig_in,
  input wire logic                   trig_out,
  input wire logic                   conv_tick,
  input wire logic                   sample_tick,
  input wire logic [63:0]            timestamp,
  input wire logic                   cfg_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  ack_follows_req_a: assert property ((par_wr || par_rd) |=> par_ack) else $error("access not acked");
  ack_has_cause_a: assert property (par_ack |-> $past(par_wr || par_rd)) else $error("ack without access");
  bad_mode_err_a: assert property (par_wr && par_addr == `SCS_ADDR_MODE && par_wdata == 32'h3 |=> par_err)
    else $error("two-hot mode accepted");
  term_input_only_a: assert property (term_en |-> !ext_clk_oe) else $error("termination while driving");
  clkout_internal_a: assert property (ext_clk_oe |-> !pll_ref_ext) else $error("clock out in reference mode");
  one_source_a: assert property (!(osc2_sel && pll_ref_ext)) else $error("two sources selected");
  osc2_on_write_a: assert property (par_wr && par_addr == `SCS_ADDR_MODE && par_wdata == 32'h4 |=> osc2_sel)
    else $error("second oscillator not selected");
  ref_on_write_a: assert property (par_wr && par_addr == `SCS_ADDR_MODE && par_wdata == 32'h20 |=> pll_ref_ext)
    else $error("connector reference not selected");
  stamp_step_a: assert property ($changed(timestamp) |-> timestamp == $past(timestamp) + 64'h1)
    else $error("timestamp jumped");
  busy_on_rate_a: assert property (par_wr && par_addr == `SCS_ADDR_SRATE |=> cfg_busy) else $error("rate not busy");
  busy_bounded_a: assert property ($rose(cfg_busy) |-> ##[1:400] !cfg_busy) else $error("calc hung");
endmodule

// ===== testbench/test_sample_clock_source_control.sv
`include "scs_consts.svh"
module test_sample_clock_source_control
  import scs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   sys_clk, resetn, par_wr, par_rd, par_ack, par_err, trig_in;
  logic [`SCS_ADDR_W-1:0] par_addr;
  logic [31:0]            par_wdata, par_rdata, q;
  logic                   ext_clk_o, ext_clk_oe, term_en, pll_ref_ext, osc2_sel;
  logic                   trig_out, conv_tick, sample_tick, cfg_busy, conn;
  logic [63:0]            timestamp;
  int                     mismatches, checks_done, cycles;
  scs_top DUT (.sys_clk(sys_clk), .resetn(resetn), .par_addr(par_addr), .par_wr(par_wr), .par_rd(par_rd),
    .par_wdata(par_wdata), .par_rdata(par_rdata), .par_ack(par_ack), .par_err(par_err), .ext_clk_o(ext_clk_o),
    .ext_clk_oe(ext_clk_oe), .term_en(term_en), .pll_ref_ext(pll_ref_ext), .osc2_sel(osc2_sel),
    .trig_in(trig_in), .trig_out(trig_out), .conv_tick(conv_tick), .sample_tick(sample_tick),
    .timestamp(timestamp), .cfg_busy(cfg_busy));
  scs_ext_clk_src #(.REF_HZ(10000000)) src (.drv_oe(ext_clk_oe), .drv_lvl(ext_clk_o), .conn(conn));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // ack and err stand one cycle, so they are looked at in the ack cycle
  task automatic acc(input logic wr, input logic [17:0] a, input logic [31:0] d, input logic e);
    @(negedge sys_clk);
    par_wr = wr;
    par_rd = !wr;
    par_addr = a;
    par_wdata = d;
    @(negedge sys_clk);
    par_wr = 1'b0;
    par_rd = 1'b0;
    cmp("ack", par_ack, 1'b1);
    cmp("err", par_err, e);
    q = par_rdata;
  endtask
  task automatic rd(input logic [17:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, 1'b0);
    cmp("read data", q, exp);
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 1000 && cfg_busy !== 1'b0; n++)
      @(negedge sys_clk);
    cmp("busy", cfg_busy, 1'b0);
  endtask
  // cycles and timestamp steps between two pulses of one tick
  task automatic period(input logic smp, input int exp, input int ts_exp, input int hi_exp);
    int c;
    int h;
    logic [63:0] t0;
    c = 0;
    h = 0;
    while ((smp ? sample_tick : conv_tick) !== 1'b1 && c < 3000) begin
      @(negedge sys_clk);
      c++;
    end
    t0 = timestamp;
    c = 0;
    do begin
      @(negedge sys_clk);
      c++;
      h += (ext_clk_o === 1'b1);
    end while ((smp ? sample_tick : conv_tick) !== 1'b1 && c < 3000);
    cmp("tick period", c, exp);
    cmp("stamp step", timestamp - t0, ts_exp);
    cmp("clock high", h, hi_exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(`SCS_ADDR_MODE, 32'h1);
    rd(`SCS_ADDR_OS_RATIO, 32'h1);
    rd(`SCS_ADDR_SRATE, 32'h02faf080);
    $display("done reset values");
  endtask
  task automatic t_osc2();
    acc(1'b1, `SCS_ADDR_MODE, 32'h4, 1'b0);
    @(negedge sys_clk);
    cmp("osc2 select", osc2_sel, 1'b1);
    rd(`SCS_ADDR_MODE, 32'h4);
    acc(1'b1, `SCS_ADDR_SRATE, 32'h002dc6c0, 1'b0);
    wait_idle();
    rd(`SCS_ADDR_SRATE, 32'h002ce0f8);
    rd(`SCS_ADDR_OS_RATIO, 32'h1);
    acc(1'b1, `SCS_ADDR_CLKOUT, 32'h1, 1'b0);
    acc(1'b1, `SCS_ADDR_TERM, 32'h1, 1'b0);
    @(negedge sys_clk);
    cmp("clock out", ext_clk_oe, 1'b1);
    cmp("termination", term_en, 1'b0);
    cmp("connector", conn, ext_clk_o);
    rd(`SCS_ADDR_CLKOUT_FREQ, 32'h002ce0f8);
    period(1'b0, 17, 1, 8);
    $display("done second oscillator");
  endtask
  task automatic t_over();
    int n;
    acc(1'b1, `SCS_ADDR_SRATE, 32'h000186a0, 1'b0);
    wait_idle();
    rd(`SCS_ADDR_OS_RATIO, 32'h5);
    rd(`SCS_ADDR_SRATE, 32'h000186a0);
    rd(`SCS_ADDR_CLKOUT_FREQ, 32'h0007a120);
    // oversampled: no pipeline compensation, only the two sync stages and one flop
    trig_in = 1'b1;
    n = 0;
    while (trig_out !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    cmp("raw trigger delay", n, 3);
    trig_in = 1'b0;
    period(1'b1, 500, 5, 250);
    period(1'b0, 100, 1, 50);
    $display("done oversampling");
  endtask
  task automatic t_extref();
    int n;
    acc(1'b1, `SCS_ADDR_CLKOUT, 32'h0, 1'b0);
    acc(1'b1, `SCS_ADDR_MODE, 32'h20, 1'b0);
    @(negedge sys_clk);
    cmp("ref from connector", pll_ref_ext, 1'b1);
    cmp("term on input", term_en, 1'b1);
    acc(1'b1, `SCS_ADDR_CLKOUT, 32'h1, 1'b1);
    acc(1'b1, `SCS_ADDR_REF_HZ, 32'h0bebc200, 1'b1);
    acc(1'b1, `SCS_ADDR_REF_HZ, 32'h000f423f, 1'b1);
    rd(`SCS_ADDR_REF_HZ, 32'h00989680);
    acc(1'b1, `SCS_ADDR_REF_HZ, 32'h07735940, 1'b0);
    acc(1'b1, `SCS_ADDR_REF_HZ, 32'h00989680, 1'b0);
    acc(1'b1, `SCS_ADDR_SRATE, 32'h017d7840, 1'b0);
    wait_idle();
    rd(`SCS_ADDR_SRATE, 32'h017d7840);
    acc(1'b1, `SCS_ADDR_SRATE, 32'h01c9c380, 1'b0);
    wait_idle();
    rd(`SCS_ADDR_SRATE, 32'h01ce6336);
    period(1'b0, 33, 1, 16);
    trig_in = 1'b1;
    n = 0;
    for (int c = 0; c < 2000 && trig_out !== 1'b1; c++) begin
      @(negedge sys_clk);
      n += (conv_tick === 1'b1);
    end
    cmp("trigger delay", n >= 8 && n <= 9, 1'b1);
    trig_in = 1'b0;
    $display("done external reference");
  endtask
  task automatic t_errs();
    acc(1'b1, `SCS_ADDR_MODE, 32'h3, 1'b1);
    rd(`SCS_ADDR_MODE, 32'h20);
    acc(1'b1, `SCS_ADDR_OS_RATIO, 32'h5, 1'b1);
    acc(1'b0, 18'h00001, 32'h0, 1'b1);
    cmp("unmapped data", q, 32'h0);
    $display("done refusals");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    resetn = 1'b0;
    {par_wr, par_rd, trig_in} = 3'h0;
    par_addr = '0;
    par_wdata = 32'h0;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    t_reset();
    t_osc2();
    t_over();
    t_extref();
    t_errs();
    tally_and_finish();
  end
endmodule
bind scs_top scs_top_monitor u_mon (.sys_clk(sys_clk), .resetn(resetn), .par_addr(par_addr), .par_wr(par_wr),
  .par_rd(par_rd), .par_wdata(par_wdata), .par_rdata(par_rdata), .par_ack(par_ack), .par_err(par_err),
  .ext_clk_o(ext_clk_o), .ext_clk_oe(ext_clk_oe), .term_en(term_en), .pll_ref_ext(pll_ref_ext),
  .osc2_sel(osc2_sel), .trig_in(trig_in), .trig_out(trig_out), .conv_tick(conv_tick),
  .sample_tick(sample_tick), .timestamp(timestamp), .cfg_busy(cfg_busy));
